/* logic/obcd_decoder.v */
// option byte configuration decoder: option store, decode and consumers
// assumes: one 40 MHz clock, sync reset, option store kept over rst_i
// and cleared only by por_i; oscillator pins are asynchronous
//
// Operation
// - the slow oscillator may be granted as cpu clock only when allowed.
// - the independent watchdog runs from reset if hw start, else on sw start.
// - the window watchdog runs from reset if hw start, else on sw start.
// - halt entry with the window watchdog active resets only if enabled.
// - external clock select picks driven clock or crystal on the osc pins.
// - wakeup clock is the slow oscillator at 0, prescaled fast clock at 1.
// - the prescaler field divides 24, 16, 8 or 4 MHz down to 128 kHz.
// - the settle field sets 2048, 128, 8 or 0.5 crystal cycles of wait.
// - flash reads take one wait state when the wait bit is set, else none.
// - the boot vector fetch follows reset release within 150 us.
`timescale 1ns/1ps
`default_nettype none
`include "obcd_consts.vh"

module obcd_decoder #(
  parameter BOOT_MAX_CYC = `OBCD_BOOT_MAX_CYC
) (
  // clock and resets
  input wire mclk_i,
  input wire rst_i,
  input wire por_i,
  // register port
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // clock controller
  input wire cpu_slow_req_i,
  output wire cpu_slow_grant_o,
  output wire external_clock_select_o,
  output wire osc_amp_en_o,
  input wire osc_start_i,
  output wire osc_ready_o,
  // oscillator pins
  input wire osc_in_pin_i,
  input wire slow_osc_i,
  // watchdogs
  input wire indep_wdg_sw_start_i,
  input wire window_wdg_sw_start_i,
  input wire halt_i,
  output wire indep_wdg_run_o,
  output wire window_wdg_run_o,
  output reg halt_reset_o,
  // auto-wakeup unit
  output wire wakeup_clock_select_o,
  output reg wakeup_tick_o,
  // memory interface
  input wire mem_rd_req_i,
  output wire mem_rd_ack_o,
  // boot
  input wire boot_ready_i,
  output reg boot_fetch_o,
  output wire boot_done_o
);

  // ****************************************
  // functions
  // ****************************************
  function [14:0] obcd_in_khz;
    input [1:0] prsc;
    begin
      case (prsc)
        `OBCD_PRSC_24M: obcd_in_khz = `OBCD_KHZ_24M;
        `OBCD_PRSC_16M: obcd_in_khz = `OBCD_KHZ_16M;
        `OBCD_PRSC_8M: obcd_in_khz = `OBCD_KHZ_8M;
        default: obcd_in_khz = `OBCD_KHZ_4M;
      endcase
    end
  endfunction

  function [12:0] obcd_settle_half;
    input [7:0] code;
    begin
      case (code)
        `OBCD_XTAL_128: obcd_settle_half = `OBCD_HALF_128;
        `OBCD_XTAL_8: obcd_settle_half = `OBCD_HALF_8;
        `OBCD_XTAL_HALF: obcd_settle_half = `OBCD_HALF_1;
        default: obcd_settle_half = `OBCD_HALF_2048;
      endcase
    end
  endfunction

  // ****************************************
  // option store, kept across system reset
  // ****************************************
  reg [7:0] wdg_clk_opt;
  reg [7:0] clk_src_opt;
  reg [7:0] xtal_opt;
  reg [7:0] flash_opt;

  always @(posedge mclk_i) begin
    if (por_i) begin
      wdg_clk_opt <= `OBCD_RST_WDG_CLK;
      clk_src_opt <= `OBCD_RST_CLK_SRC;
      xtal_opt <= `OBCD_RST_XTAL;
      flash_opt <= `OBCD_RST_FLASH;
    end else if (wr_i && !rst_i) begin
      case (addr_i)
        `OBCD_ADDR_WDG_CLK: wdg_clk_opt <= wdata_i;
        `OBCD_ADDR_CLK_SRC: clk_src_opt <= wdata_i;
        `OBCD_ADDR_XTAL: xtal_opt <= wdata_i;
        `OBCD_ADDR_FLASH: flash_opt <= wdata_i;
        default: ;
      endcase
    end
  end

  // ****************************************
  // active settings
  // ****************************************
  reg slow_osc_cpu_allow;
  reg indep_watchdog_hw_start;
  reg window_watchdog_hw_start;
  reg window_watchdog_halt_reset;
  reg external_clock_select;
  reg wakeup_clock_select;
  reg [1:0] wakeup_prescaler;
  reg [7:0] crystal_settle_count;
  reg flash_wait_select;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      slow_osc_cpu_allow <= wdg_clk_opt[`OBCD_BIT_SLOW_ALLOW];
      indep_watchdog_hw_start <= wdg_clk_opt[`OBCD_BIT_INDEP_WATCHDOG_HW_START];
      window_watchdog_hw_start <= wdg_clk_opt[`OBCD_BIT_WINDOW_WATCHDOG_HW_START];
      window_watchdog_halt_reset <= wdg_clk_opt[`OBCD_BIT_WINDOW_WATCHDOG_HALT_RESET];
      external_clock_select <= clk_src_opt[`OBCD_BIT_EXT_CLK];
      wakeup_clock_select <= clk_src_opt[`OBCD_BIT_WAKE_SEL];
      wakeup_prescaler <= clk_src_opt[`OBCD_PRSC_HI:`OBCD_PRSC_LO];
      crystal_settle_count <= xtal_opt;
      flash_wait_select <= flash_opt[`OBCD_BIT_WAIT];
    end
  end

  // ****************************************
  // clock source
  // ****************************************
  // slow oscillator grant
  assign cpu_slow_grant_o = cpu_slow_req_i & slow_osc_cpu_allow;
  assign external_clock_select_o = external_clock_select;
  assign osc_amp_en_o = ~external_clock_select;

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [2:0] fast_sync;
  reg [2:0] slow_sync;
  reg fast_lvl;
  reg slow_lvl;
  wire fast_rise;
  wire fast_edge;
  wire slow_rise;

  // level follows the pin in reset, so no false edge follows release
  always @(posedge mclk_i) begin
    fast_sync <= {fast_sync[1:0], osc_in_pin_i};
    slow_sync <= {slow_sync[1:0], slow_osc_i};
    if (rst_i || fast_sync[1] == fast_sync[2]) begin
      fast_lvl <= fast_sync[2];
    end
    if (rst_i || slow_sync[1] == slow_sync[2]) begin
      slow_lvl <= slow_sync[2];
    end
  end

  assign fast_edge = (fast_sync[1] == fast_sync[2]) &&
                     (fast_sync[2] != fast_lvl);
  assign fast_rise = fast_edge & fast_sync[2];
  assign slow_rise = (slow_sync[1] == slow_sync[2]) & slow_sync[2] &
                     ~slow_lvl;

  // ****************************************
  // crystal settle counter
  // ****************************************
  reg [12:0] settle_cnt;
  reg settle_busy;
  reg osc_ready;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      settle_cnt <= 13'h0000;
      settle_busy <= 1'b0;
      osc_ready <= 1'b0;
    end else if (!osc_start_i) begin
      settle_busy <= 1'b0;
      osc_ready <= 1'b0;
    end else if (!settle_busy && !osc_ready) begin
      settle_cnt <= obcd_settle_half(crystal_settle_count);
      settle_busy <= 1'b1;
    end else if (settle_busy && fast_edge) begin
      if (settle_cnt == 13'h0001) begin
        settle_busy <= 1'b0;
        osc_ready <= 1'b1;
      end
      settle_cnt <= settle_cnt - 13'h0001;
    end
  end

  assign osc_ready_o = osc_ready;

  // ****************************************
  // auto-wakeup clock
  // ****************************************
  reg [14:0] wake_acc;
  reg wake_pre_tick;
  wire [14:0] wake_sum;
  wire [14:0] wake_lim;

  assign wake_sum = wake_acc + `OBCD_WAKE_OUT_KHZ;
  assign wake_lim = obcd_in_khz(wakeup_prescaler);

  always @(posedge mclk_i) begin
    if (rst_i) begin
      wake_acc <= 15'h0000;
      wake_pre_tick <= 1'b0;
    end else begin
      wake_pre_tick <= 1'b0;
      if (fast_rise) begin
        if (wake_sum >= wake_lim) begin
          wake_acc <= wake_sum - wake_lim;
          wake_pre_tick <= 1'b1;
        end else begin
          wake_acc <= wake_sum;
        end
      end
    end
  end

  always @(posedge mclk_i) begin
    wakeup_tick_o <= ~rst_i &
                     (wakeup_clock_select ? wake_pre_tick : slow_rise);
  end

  assign wakeup_clock_select_o = wakeup_clock_select;

  // ****************************************
  // watchdogs
  // ****************************************
  reg indep_sw_run;
  reg window_sw_run;
  reg halt_q;

  always @(posedge mclk_i) begin
    indep_sw_run <= ~rst_i & (indep_sw_run | indep_wdg_sw_start_i);
    window_sw_run <= ~rst_i & (window_sw_run | window_wdg_sw_start_i);
  end

  assign indep_wdg_run_o = indep_watchdog_hw_start | indep_sw_run;
  assign window_wdg_run_o = window_watchdog_hw_start | window_sw_run;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      halt_q <= 1'b0;
      halt_reset_o <= 1'b0;
    end else begin
      halt_q <= halt_i;
      halt_reset_o <= halt_i & ~halt_q & window_wdg_run_o &
                      window_watchdog_halt_reset;
    end
  end

  // ****************************************
  // memory wait state
  // ****************************************
  reg waited;

  always @(posedge mclk_i) begin
    waited <= ~rst_i & mem_rd_req_i & flash_wait_select & ~waited;
  end

  assign mem_rd_ack_o = mem_rd_req_i & (~flash_wait_select | waited);

  // ****************************************
  // boot fetch
  // ****************************************
  reg [12:0] boot_cnt;
  reg boot_done;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      boot_cnt <= 13'h0000;
      boot_done <= 1'b0;
      boot_fetch_o <= 1'b0;
    end else begin
      boot_fetch_o <= 1'b0;
      if (!boot_done) begin
        boot_cnt <= boot_cnt + 13'h0001;
        if (boot_ready_i || boot_cnt == BOOT_MAX_CYC[12:0] - 13'h0002) begin
          boot_done <= 1'b1;
          boot_fetch_o <= 1'b1;
        end
      end
    end
  end

  assign boot_done_o = boot_done;

  // ****************************************
  // register read
  // ****************************************
  always @(posedge mclk_i) begin
    if (rst_i || !rd_i) begin
      rdata_o <= 8'h00;
    end else begin
      case (addr_i)
        `OBCD_ADDR_WDG_CLK: rdata_o <= wdg_clk_opt;
        `OBCD_ADDR_CLK_SRC: rdata_o <= clk_src_opt;
        `OBCD_ADDR_XTAL: rdata_o <= xtal_opt;
        `OBCD_ADDR_FLASH: rdata_o <= flash_opt;
        `OBCD_ADDR_STATUS: rdata_o <= {2'h0, boot_done, osc_ready,
          window_wdg_run_o, indep_wdg_run_o, external_clock_select,
          flash_wait_select};
        default: rdata_o <= 8'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

/* logic/obcd_consts.vh */
// constants for the option byte configuration decoder
// assumes: included by logic/obcd_decoder.v only
`ifndef OBCD_CONSTS_VH
`define OBCD_CONSTS_VH

// ****************************************
// register offsets (4-bit address)
// ****************************************
`define OBCD_ADDR_WDG_CLK 4'h0
`define OBCD_ADDR_CLK_SRC 4'h1
`define OBCD_ADDR_XTAL 4'h2
`define OBCD_ADDR_RSVD 4'h3
`define OBCD_ADDR_FLASH 4'h4
`define OBCD_ADDR_STATUS 4'h8

// ****************************************
// power-on values of the option store
// ****************************************
`define OBCD_RST_WDG_CLK 8'h00
`define OBCD_RST_CLK_SRC 8'h00
`define OBCD_RST_XTAL 8'h00
`define OBCD_RST_FLASH 8'h00

// ****************************************
// field positions
// ****************************************
`define OBCD_BIT_SLOW_ALLOW 3
`define OBCD_BIT_INDEP_WATCHDOG_HW_START 2
`define OBCD_BIT_WINDOW_WATCHDOG_HW_START 1
`define OBCD_BIT_WINDOW_WATCHDOG_HALT_RESET 0
`define OBCD_BIT_EXT_CLK 3
`define OBCD_BIT_WAKE_SEL 2
`define OBCD_PRSC_HI 1
`define OBCD_PRSC_LO 0
`define OBCD_BIT_WAIT 0

// ****************************************
// wakeup prescaler: input rates in kHz
// ****************************************
`define OBCD_WAKE_OUT_KHZ 15'h0080
`define OBCD_PRSC_24M 2'h0
`define OBCD_PRSC_16M 2'h1
`define OBCD_PRSC_8M 2'h2
`define OBCD_PRSC_4M 2'h3
`define OBCD_KHZ_24M 15'h5DC0
`define OBCD_KHZ_16M 15'h3E80
`define OBCD_KHZ_8M 15'h1F40
`define OBCD_KHZ_4M 15'h0FA0

// ****************************************
// crystal settle codes, waits in half cycles
// ****************************************
`define OBCD_XTAL_2048 8'h00
`define OBCD_XTAL_128 8'hB4
`define OBCD_XTAL_8 8'hD2
`define OBCD_XTAL_HALF 8'hE1
`define OBCD_HALF_2048 13'h1000
`define OBCD_HALF_128 13'h0100
`define OBCD_HALF_8 13'h0010
`define OBCD_HALF_1 13'h0001

// ****************************************
// timing
// ****************************************
`define OBCD_CLK_MHZ 40
`define OBCD_BOOT_MAX_US 150
`define OBCD_BOOT_MAX_CYC (`OBCD_BOOT_MAX_US * `OBCD_CLK_MHZ)

`endif

/* dv/obcd_decoder_asserts.sv */
// port checker for the option byte decoder
// assumes: bound onto obcd_decoder, one clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module obcd_asserts #(
  parameter BOOT_MAX_CYC = 6000
) (
  // clock, reset and register port
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // clock controller
  input wire logic cpu_slow_req_i,
  input wire logic cpu_slow_grant_o,
  input wire logic external_clock_select_o,
  input wire logic osc_amp_en_o,
  input wire logic wakeup_clock_select_o,
  input wire logic wakeup_tick_o,
  // watchdogs
  input wire logic indep_wdg_sw_start_i,
  input wire logic window_wdg_sw_start_i,
  input wire logic indep_wdg_run_o,
  input wire logic window_wdg_run_o,
  input wire logic halt_i,
  input wire logic halt_reset_o,
  // memory and boot
  input wire logic mem_rd_req_i,
  input wire logic mem_rd_ack_o,
  input wire logic boot_fetch_o
);
  localparam int BOOT_W = BOOT_MAX_CYC;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_grant; cpu_slow_grant_o |-> cpu_slow_req_i; endproperty
  a_grant: assert property (p_grant) else $error("grant without request");
  property p_indep; indep_wdg_sw_start_i |=> ##[0:2] indep_wdg_run_o; endproperty
  a_indep: assert property (p_indep) else $error("indep not started");
  property p_window; window_wdg_sw_start_i |=> ##[0:2] window_wdg_run_o;
  endproperty
  a_window: assert property (p_window) else $error("window not started");
  property p_halt; halt_reset_o |-> $past(halt_i) && window_wdg_run_o ##1
    !halt_reset_o; endproperty
  a_halt: assert property (p_halt) else $error("bad halt reset");
  property p_amp; osc_amp_en_o == !external_clock_select_o; endproperty
  a_amp: assert property (p_amp) else $error("amp enable wrong");
  property p_tick; wakeup_tick_o |=> !wakeup_tick_o; endproperty
  a_tick: assert property (p_tick) else $error("tick too long");
  property p_ack; mem_rd_ack_o |-> mem_rd_req_i; endproperty
  a_ack: assert property (p_ack) else $error("ack without request");
  property p_boot; $fell(rst_i) |-> ##[0:BOOT_W] boot_fetch_o; endproperty
  a_boot: assert property (p_boot) else $error("boot fetch late");
  property p_hold; !$past(rst_i) |-> $stable({external_clock_select_o,
    wakeup_clock_select_o}); endproperty
  a_hold: assert property (p_hold) else $error("settings moved");
  property p_rdata; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
  a_rdata: assert property (p_rdata) else $error("read data stray");
endmodule
bind obcd_decoder obcd_asserts #(.BOOT_MAX_CYC(BOOT_MAX_CYC)) i_chk (
  .mclk_i, .rst_i, .rd_i, .rdata_o, .cpu_slow_req_i, .cpu_slow_grant_o,
  .external_clock_select_o, .osc_amp_en_o, .wakeup_clock_select_o,
  .wakeup_tick_o, .indep_wdg_sw_start_i, .window_wdg_sw_start_i,
  .indep_wdg_run_o, .window_wdg_run_o, .halt_i, .halt_reset_o,
  .mem_rd_req_i, .mem_rd_ack_o, .boot_fetch_o);
`default_nettype wire

/* dv/obcd_decoder_tb.sv */
// self-checking bench for the option byte decoder
// assumes: decoder and checker compiled first, 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module obcd_decoder_tb;
  localparam int BOOT = 40;
  logic mclk_i, rst_i, por_i, wr_i, rd_i, cpu_slow_req_i, osc_start_i;
  logic osc_in_pin_i, slow_osc_i, indep_wdg_sw_start_i, halt_i;
  logic window_wdg_sw_start_i, mem_rd_req_i, boot_ready_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  wire [7:0] rdata_o;
  wire cpu_slow_grant_o, external_clock_select_o, osc_amp_en_o, osc_ready_o;
  wire indep_wdg_run_o, window_wdg_run_o, halt_reset_o, wakeup_tick_o;
  wire wakeup_clock_select_o, mem_rd_ack_o, boot_fetch_o, boot_done_o;
  int error_cnt = 0;
  int tests_run = 0;
  int ticks = 0;
  obcd_decoder #(.BOOT_MAX_CYC(BOOT)) i_dut (.mclk_i, .rst_i, .por_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cpu_slow_req_i,
    .cpu_slow_grant_o, .external_clock_select_o, .osc_amp_en_o,
    .osc_start_i, .osc_ready_o, .osc_in_pin_i, .slow_osc_i,
    .indep_wdg_sw_start_i, .window_wdg_sw_start_i, .halt_i,
    .indep_wdg_run_o, .window_wdg_run_o, .halt_reset_o,
    .wakeup_clock_select_o, .wakeup_tick_o, .mem_rd_req_i, .mem_rd_ack_o,
    .boot_ready_i, .boot_fetch_o, .boot_done_o);
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) if (wakeup_tick_o === 1'b1) ticks <= ticks + 1;
  // ****************************************
  // helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
    @(posedge mclk_i);
  endtask
  task automatic tog(input int n, input bit slow);
    repeat (n) begin
      if (slow) slow_osc_i <= ~slow_osc_i;
      else osc_in_pin_i <= ~osc_in_pin_i;
      cyc(3);
    end
  endtask
  task automatic rst_seq;
    bit seen;
    seen = 1'b0;
    rst_i <= 1'b1;
    cyc(16);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    repeat (BOOT + 4) begin
      @(posedge mclk_i);
      #1 if (boot_fetch_o === 1'b1) seen = 1'b1;
    end
    @(posedge mclk_i);
    chk(seen, 1);
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    rdc(4'h0, 8'h00); rdc(4'h1, 8'h00); rdc(4'h2, 8'h00);
    rdc(4'h4, 8'h00);
    wr(4'h3, 8'hFF); rdc(4'h3, 8'h00); wr(4'h5, 8'hAA); rdc(4'h5, 8'h00);
    wr(4'h0, 8'h09); wr(4'h1, 8'h0F); wr(4'h2, 8'hE1); wr(4'h4, 8'h01);
    rdc(4'h0, 8'h09); rdc(4'h1, 8'h0F); rdc(4'h2, 8'hE1); rdc(4'h4, 8'h01);
    chk(external_clock_select_o, 0);
  endtask
  task automatic t_cfg_sw;
    rst_seq();
    #1 chk({external_clock_select_o, osc_amp_en_o}, 2'b10);
    chk(wakeup_clock_select_o, 1);
    chk({indep_wdg_run_o, window_wdg_run_o, cpu_slow_grant_o}, 3'b001);
    rdc(4'h8, 8'h23);
    halt_i <= 1'b1; cyc(1); #1 chk(halt_reset_o, 0); cyc(3);
    halt_i <= 1'b0; window_wdg_sw_start_i <= 1'b1; cyc(1);
    window_wdg_sw_start_i <= 1'b0; cyc(3); chk(window_wdg_run_o, 1);
    halt_i <= 1'b1; cyc(1); #1 chk(halt_reset_o, 1);
    cyc(1); halt_i <= 1'b0; indep_wdg_sw_start_i <= 1'b1; cyc(1);
    indep_wdg_sw_start_i <= 1'b0; cyc(3); chk(indep_wdg_run_o, 1);
    mem_rd_req_i <= 1'b1; #1 chk(mem_rd_ack_o, 0);
    cyc(1); #1 chk(mem_rd_ack_o, 1);
    cyc(1); mem_rd_req_i <= 1'b0;
    osc_start_i <= 1'b1; cyc(6); chk(osc_ready_o, 0);
    tog(1, 0); cyc(5); chk(osc_ready_o, 1);
  endtask
  task automatic t_cfg_hw;
    int t0;
    wr(4'h0, 8'h06); wr(4'h1, 8'h00); wr(4'h2, 8'hD2); wr(4'h4, 8'h00);
    osc_start_i <= 1'b0; cpu_slow_req_i <= 1'b1;
    rst_seq();
    #1 chk({indep_wdg_run_o, window_wdg_run_o}, 2'b11);
    chk({osc_amp_en_o, cpu_slow_grant_o}, 2'b10);
    halt_i <= 1'b1; cyc(1); #1 chk(halt_reset_o, 0);
    mem_rd_req_i <= 1'b1; cyc(1); #1 chk(mem_rd_ack_o, 1);
    cyc(1); mem_rd_req_i <= 1'b0; halt_i <= 1'b0; osc_start_i <= 1'b1;
    tog(15, 0); chk(osc_ready_o, 0);
    tog(1, 0); cyc(5); chk(osc_ready_o, 1);
    t0 = ticks;
    tog(8, 1); cyc(6); chk(ticks - t0, 4);
  endtask
  task automatic t_prsc;
    int t0;
    logic [7:0] exp [4] = '{8'h01, 8'h02, 8'h05, 8'h0B};
    for (int p = 0; p < 4; p++) begin
      wr(4'h1, 8'h04 | 8'(p));
      rst_seq();
      t0 = ticks;
      tog(748, 0); cyc(8); chk(ticks - t0, exp[p]);
    end
  endtask
  task automatic t_boot;
    wr(4'h2, 8'hB4);
    boot_ready_i <= 1'b1;
    rst_i <= 1'b1;
    cyc(16);
    rst_i <= 1'b0;
    cyc(1);
    #1 chk(boot_fetch_o, 1);
    cyc(1);
    #1 chk({boot_fetch_o, boot_done_o}, 2'b01);
    cyc(1);
    boot_ready_i <= 1'b0;
    tog(255, 0);
    chk(osc_ready_o, 0);
    tog(1, 0);
    cyc(5);
    chk(osc_ready_o, 1);
  endtask
  initial begin
    {rst_i, por_i} = 2'b11;
    {wr_i, rd_i, cpu_slow_req_i, osc_start_i, osc_in_pin_i} = 5'h00;
    {slow_osc_i, indep_wdg_sw_start_i, window_wdg_sw_start_i} = 3'h0;
    {halt_i, mem_rd_req_i, boot_ready_i} = 3'h0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    rst_seq();
    t_regs();
    cpu_slow_req_i <= 1'b1;
    t_cfg_sw();
    t_cfg_hw();
    t_prsc();
    t_boot();
    complete_run();
  end
  initial begin
    #2500000;
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
